// ---- common/stq_pkg.sv ----
// Constants and types shared by the SPI transmit queue manager
package stq_pkg;
    // Register offsets
    localparam logic [7:0] OFS_TX_CONTROL = 8'h70;
    localparam logic [7:0] OFS_TX_STATUS  = 8'h72;
    localparam logic [7:0] OFS_TX_FREE    = 8'h78;
    localparam logic [7:0] OFS_TX_QCMD    = 8'h80;
    localparam logic [7:0] OFS_RX_QCMD    = 8'h82;
    localparam logic [7:0] OFS_TX_DPTR    = 8'h84;
    localparam logic [7:0] OFS_IRQ_EN     = 8'h90;
    localparam logic [7:0] OFS_IRQ_STAT   = 8'h92;
    localparam logic [7:0] OFS_SPACE_REQ  = 8'h9e;
    // Command opcodes
    localparam logic [1:0] OP_REG_RD = 2'h0;
    localparam logic [1:0] OP_REG_WR = 2'h1;
    localparam logic [1:0] OP_RXQ_RD = 2'h2;
    localparam logic [1:0] OP_TXQ_WR = 2'h3;
    // Transmit memory
    localparam logic [12:0] TXQ_SIZE  = 13'h1800;
    localparam int          TXQ_DEPTH = 32'(TXQ_SIZE);
    localparam logic [12:0] HDR_BYTES = 13'h0004;
    localparam logic [15:0] REG_RESET = 16'h0000;
    // Field positions
    localparam int CTL_TX_EN  = 0;
    localparam int CTL_CRC    = 1;
    localparam int CTL_PAD    = 2;
    localparam int CTL_FLOW   = 3;
    localparam int QC_MANUAL  = 0;
    localparam int QC_SPACE   = 1;
    localparam int QC_AUTO    = 2;
    localparam int RQ_DMA     = 3;
    localparam int DP_AUTO    = 14;
    localparam int DP_MSB     = 10;
    localparam int IRQ_DONE   = 14;
    localparam int IRQ_SPACE  = 6;
    localparam int CW_IRQ     = 15;
    localparam int TAG_MSB    = 5;
    localparam int TXS_DONE   = 15;
    localparam int TXS_BUSY   = 14;
    // Transmit sequencer states, Gray along the path
    typedef enum logic [1:0] {
        TX_IDLE = 2'h0,
        TX_HDR  = 2'h1,
        TX_DATA = 2'h3,
        TX_DONE = 2'h2
    } stq_tx_state_t;
endpackage

// ---- src/stq_top.sv ----
// SPI slave front end and transmit queue manager
`timescale 1ns/1ps
module stq_top
    import stq_pkg::*;
(
    // Core clock and reset
    input  logic       clock,
    input  logic       reset,
    // Serial link
    input  logic       spi_sclk,
    input  logic       chip_select_n,
    input  logic       spi_si,
    output logic       spi_so,
    output logic       spi_so_oe_n,
    // Byte stream to the MAC
    output logic       mac_tx_valid,
    output logic [7:0] mac_tx_data,
    output logic       mac_tx_last,
    input  logic       mac_tx_ready,
    // MAC options
    output logic       mac_tx_enable,
    output logic       mac_crc_enable,
    output logic       mac_pad_enable,
    output logic       mac_flow_enable,
    // Host interrupt
    output logic       irq
);

    function automatic logic [1:0] first_lane(input logic [3:0] l);
        if (l[0])
            return 2'h0;
        else if (l[1])
            return 2'h1;
        else if (l[2])
            return 2'h2;
        return 2'h3;
    endfunction

    function automatic logic [12:0] wrap(input logic [12:0] b, input logic [12:0] a);
        logic [13:0] s;
        s = {1'b0, b} + {1'b0, a};
        if (s >= {1'b0, TXQ_SIZE})
            s = s - {1'b0, TXQ_SIZE};
        return s[12:0];
    endfunction

    // Space a frame takes, header included, in whole double words
    function automatic logic [12:0] alloc(input logic [10:0] n);
        logic [12:0] s;
        s = 13'(n) + HDR_BYTES + 13'h3;
        return {s[12:2], 2'h0};
    endfunction

    function automatic logic [15:0] merge(input logic [15:0] o, input logic h,
                                          input logic [7:0] b);
        return h ? {b, o[7:0]} : {o[15:8], b};
    endfunction

    // ---------------- Link domain ----------------
    logic        spi_clear;
    logic [2:0]  bit_cnt;
    logic [6:0]  sh_in;
    logic        cmd0_done;
    logic        data_ph;
    logic [1:0]  op;
    logic [3:0]  lanes;
    logic [5:0]  addr;
    logic [7:0]  in_byte;
    logic [7:0]  so_sh;
    logic        ev_tog;
    logic [7:0]  ev_data;
    logic        ev_fifo;
    logic [1:0]  ev_lane;
    logic [5:0]  ev_addr;
    logic        rd_tog;
    logic [5:0]  rd_addr;
    logic [31:0] rd_word;

    assign spi_clear = chip_select_n | reset;
    assign in_byte   = {sh_in, spi_si};

    // Command and lane tracking, sampled on rising edges
    always_ff @(posedge spi_sclk or posedge spi_clear)
    begin
        if (spi_clear)
        begin
            bit_cnt   <= 3'h0;
            sh_in     <= 7'h00;
            cmd0_done <= 1'b0;
            data_ph   <= 1'b0;
            op        <= OP_REG_RD;
            lanes     <= 4'h0;
            addr      <= 6'h00;
        end
        else
        begin
            sh_in   <= in_byte[6:0];
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7)
            begin
                if (!cmd0_done)
                begin
                    op        <= in_byte[7:6];
                    lanes     <= in_byte[5:2];
                    addr[5:4] <= in_byte[1:0];
                    data_ph   <= in_byte[7];
                    cmd0_done <= 1'b1;
                end
                else if (!data_ph)
                begin
                    addr[3:0] <= in_byte[7:4];
                    data_ph   <= 1'b1;
                end
                else if (!op[1])
                    lanes <= lanes & (lanes - 4'h1);
            end
        end
    end

    // Written bytes are posted to the core with a toggle
    always_ff @(posedge spi_sclk or posedge reset)
    begin
        if (reset)
        begin
            ev_tog  <= 1'b0;
            ev_data <= 8'h00;
            ev_fifo <= 1'b0;
            ev_lane <= 2'h0;
            ev_addr <= 6'h00;
        end
        else if (bit_cnt == 3'h7 && data_ph &&
                 (op == OP_TXQ_WR || (op == OP_REG_WR && lanes != 4'h0)))
        begin
            ev_tog  <= ~ev_tog;
            ev_data <= in_byte;
            ev_fifo <= op[1];
            ev_lane <= first_lane(lanes);
            ev_addr <= addr;
        end
    end

    // Read request leaves as soon as the address is whole, four bits early
    always_ff @(posedge spi_sclk or posedge reset)
    begin
        if (reset)
        begin
            rd_tog  <= 1'b0;
            rd_addr <= 6'h00;
        end
        else if (bit_cnt == 3'h3 && cmd0_done && !data_ph && op == OP_REG_RD)
        begin
            rd_tog  <= ~rd_tog;
            rd_addr <= {addr[5:4], in_byte[3:0]};
        end
    end

    // Output shifter; rd_word has been stable for several link clocks here
    always_ff @(negedge spi_sclk or posedge spi_clear)
    begin
        if (spi_clear)
        begin
            so_sh       <= 8'h00;
            spi_so_oe_n <= 1'b1;
        end
        else if (data_ph && !op[0] && bit_cnt == 3'h0)
        begin
            so_sh       <= op[1] ? 8'h00 : rd_word[{first_lane(lanes), 3'h0} +: 8];
            spi_so_oe_n <= !(op[1] || lanes != 4'h0);
        end
        else
            so_sh <= {so_sh[6:0], 1'b0};
    end

    assign spi_so = so_sh[7];

    // ---------------- Core domain ----------------
    logic [2:0]    ev_sy;
    logic [2:0]    rd_sy;
    logic          ev_fire;
    logic          reg_wr;
    logic          fifo_wr;
    logic [7:0]    wr_ofs;
    logic [15:0]   tx_control;
    logic [15:0]   tx_frame_status;
    logic [12:0]   tx_free_memory;
    logic [15:0]   tx_queue_command;
    logic [15:0]   rx_queue_command;
    logic [15:0]   tx_data_pointer;
    logic [15:0]   irq_enable;
    logic [15:0]   irq_status;
    logic [15:0]   tx_space_request;
    logic [7:0]    tx_mem [TXQ_DEPTH];
    logic [12:0]   head;
    logic [12:0]   tail;
    logic [9:0]    qcount;
    logic [10:0]   hdr_len;
    logic [10:0]   dp_off;
    logic          enq;
    logic          enq_auto;
    logic          enq_manual;
    logic          space_hit;
    logic          tx_done;
    stq_tx_state_t tx_state;
    logic [12:0]   rd_ptr;
    logic [1:0]    hdr_idx;
    logic [15:0]   cur_ctrl;
    logic [10:0]   cur_len;
    logic [10:0]   remain;
    logic [12:0]   cur_alloc;
    logic [15:0]   w1c_mask;

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            ev_sy <= 3'h0;
            rd_sy <= 3'h0;
        end
        else
        begin
            ev_sy <= {ev_sy[1:0], ev_tog};
            rd_sy <= {rd_sy[1:0], rd_tog};
        end
    end

    assign ev_fire = ev_sy[2] ^ ev_sy[1];
    assign reg_wr  = ev_fire && !ev_fifo;
    assign fifo_wr = ev_fire && ev_fifo && rx_queue_command[RQ_DMA];
    assign wr_ofs  = {ev_addr, ev_lane[1], 1'b0};
    assign dp_off  = tx_data_pointer[DP_MSB:0];

    function automatic logic [15:0] reg_at(input logic [7:0] o);
        if (o == OFS_TX_CONTROL)
            return tx_control;
        else if (o == OFS_TX_STATUS)
            return tx_frame_status;
        else if (o == OFS_TX_FREE)
            return 16'(tx_free_memory);
        else if (o == OFS_TX_QCMD)
            return tx_queue_command;
        else if (o == OFS_RX_QCMD)
            return rx_queue_command;
        else if (o == OFS_TX_DPTR)
            return tx_data_pointer;
        else if (o == OFS_IRQ_EN)
            return irq_enable;
        else if (o == OFS_IRQ_STAT)
            return irq_status;
        else if (o == OFS_SPACE_REQ)
            return tx_space_request;
        return REG_RESET;
    endfunction

    always_ff @(posedge clock)
    begin
        if (reset)
            rd_word <= 32'h0000_0000;
        else if (rd_sy[2] ^ rd_sy[1])
            rd_word <= {reg_at({rd_addr, 2'h2}), reg_at({rd_addr, 2'h0})};
    end

    // Plain read/write registers
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            tx_control       <= REG_RESET;
            rx_queue_command <= REG_RESET;
            irq_enable       <= REG_RESET;
            tx_space_request <= REG_RESET;
        end
        else if (reg_wr)
        begin
            if (wr_ofs == OFS_TX_CONTROL)
                tx_control <= merge(tx_control, ev_lane[0], ev_data);
            else if (wr_ofs == OFS_RX_QCMD)
                rx_queue_command <= merge(rx_queue_command, ev_lane[0], ev_data);
            else if (wr_ofs == OFS_IRQ_EN)
                irq_enable <= merge(irq_enable, ev_lane[0], ev_data);
            else if (wr_ofs == OFS_SPACE_REQ)
                tx_space_request <= merge(tx_space_request, ev_lane[0], ev_data);
        end
    end

    assign mac_tx_enable   = tx_control[CTL_TX_EN];
    assign mac_crc_enable  = tx_control[CTL_CRC];
    assign mac_pad_enable  = tx_control[CTL_PAD];
    assign mac_flow_enable = tx_control[CTL_FLOW];

    // Enqueue: manual on a fresh bit 0, automatic on the last data byte
    assign enq_manual = reg_wr && wr_ofs == OFS_TX_QCMD && !ev_lane[0] &&
                        ev_data[QC_MANUAL] && !tx_queue_command[QC_MANUAL];
    assign enq_auto   = fifo_wr && tx_queue_command[QC_AUTO] && dp_off > 11'h3 &&
                        13'(dp_off) == 13'(hdr_len) + HDR_BYTES - 13'h1;
    assign enq        = enq_manual || enq_auto;
    assign space_hit  = tx_queue_command[QC_SPACE] &&
                        {5'h00, tx_free_memory} >= {tx_space_request, 2'h0};
    assign tx_done    = tx_state == TX_DONE;
    assign cur_alloc  = alloc(cur_len);

    // Hardware clears first so that a same-cycle host set survives
    always_ff @(posedge clock)
    begin
        if (reset)
            tx_queue_command <= REG_RESET;
        else
        begin
            if (tx_done)
                tx_queue_command[QC_MANUAL] <= 1'b0;
            if (space_hit)
                tx_queue_command[QC_SPACE] <= 1'b0;
            if (reg_wr && wr_ofs == OFS_TX_QCMD && !ev_lane[0])
                tx_queue_command[QC_AUTO:0] <= ev_data[QC_AUTO:0];
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            tx_data_pointer <= REG_RESET;
        else if (enq)
        begin
            tx_data_pointer <= REG_RESET;
            tx_data_pointer[DP_AUTO] <= tx_data_pointer[DP_AUTO];
        end
        else if (fifo_wr && tx_data_pointer[DP_AUTO])
            tx_data_pointer <= tx_data_pointer + 16'h0001;
        else if (reg_wr && wr_ofs == OFS_TX_DPTR)
            tx_data_pointer <= merge(tx_data_pointer, ev_lane[0], ev_data);
    end

    // Host bytes land relative to the first free location
    always_ff @(posedge clock)
    begin
        if (fifo_wr)
            tx_mem[wrap(head, 13'(dp_off))] <= ev_data;
    end

    // Length is taken from the header as it is written
    always_ff @(posedge clock)
    begin
        if (reset)
            hdr_len <= 11'h000;
        else if (fifo_wr && dp_off == 11'h2)
            hdr_len[7:0] <= ev_data;
        else if (fifo_wr && dp_off == 11'h3)
            hdr_len[10:8] <= ev_data[2:0];
    end

    // Queue bookkeeping; header words count against free space
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            head           <= 13'h0000;
            qcount         <= 10'h000;
            tx_free_memory <= TXQ_SIZE;
        end
        else
        begin
            if (enq)
                head <= wrap(head, alloc(hdr_len));
            qcount <= qcount + 10'(enq) - 10'(tx_done);
            tx_free_memory <= tx_free_memory - (enq ? alloc(hdr_len) : 13'h0000)
                              + (tx_done ? cur_alloc : 13'h0000);
        end
    end

    // Transmit sequencer: header, data bytes, release
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            tx_state        <= TX_IDLE;
            rd_ptr          <= 13'h0000;
            tail            <= 13'h0000;
            hdr_idx         <= 2'h0;
            cur_ctrl        <= REG_RESET;
            cur_len         <= 11'h000;
            remain          <= 11'h000;
            tx_frame_status <= REG_RESET;
            mac_tx_valid    <= 1'b0;
            mac_tx_data     <= 8'h00;
            mac_tx_last     <= 1'b0;
        end
        else
        begin
            case (tx_state)
                TX_IDLE:
                    if (qcount != 10'h000 && tx_control[CTL_TX_EN])
                    begin
                        tx_state <= TX_HDR;
                        rd_ptr   <= tail;
                        hdr_idx  <= 2'h0;
                    end
                TX_HDR:
                begin
                    rd_ptr  <= wrap(rd_ptr, 13'h0001);
                    hdr_idx <= hdr_idx + 2'h1;
                    if (hdr_idx[1])
                        cur_len <= 11'(merge(16'(cur_len), hdr_idx[0], tx_mem[rd_ptr]));
                    else
                        cur_ctrl <= merge(cur_ctrl, hdr_idx[0], tx_mem[rd_ptr]);
                    if (hdr_idx == 2'h3)
                    begin
                        tx_state <= TX_DATA;
                        remain   <= {tx_mem[rd_ptr][2:0], cur_len[7:0]};
                        tx_frame_status <= {2'h1, 8'h00, cur_ctrl[TAG_MSB:0]};
                    end
                end
                TX_DATA:
                    if (!mac_tx_valid || mac_tx_ready)
                    begin
                        if (remain != 11'h000)
                        begin
                            mac_tx_valid <= 1'b1;
                            mac_tx_data  <= tx_mem[rd_ptr];
                            mac_tx_last  <= remain == 11'h001;
                            rd_ptr       <= wrap(rd_ptr, 13'h0001);
                            remain       <= remain - 11'h001;
                        end
                        else
                        begin
                            mac_tx_valid <= 1'b0;
                            mac_tx_last  <= 1'b0;
                            tx_state     <= TX_DONE;
                        end
                    end
                TX_DONE:
                begin
                    tail     <= wrap(tail, cur_alloc);
                    tx_state <= TX_IDLE;
                    tx_frame_status[TXS_DONE] <= 1'b1;
                    tx_frame_status[TXS_BUSY] <= 1'b0;
                    tx_frame_status[TAG_MSB:0] <= cur_ctrl[TAG_MSB:0];
                end
                default:
                    tx_state <= TX_IDLE;
            endcase
        end
    end

    // Status bits: write-one clears, a hardware set in the same cycle wins
    assign w1c_mask = (reg_wr && wr_ofs == OFS_IRQ_STAT) ?
                      merge(REG_RESET, ev_lane[0], ev_data) : REG_RESET;

    always_ff @(posedge clock)
    begin
        if (reset)
            irq_status <= REG_RESET;
        else
        begin
            irq_status <= irq_status & ~w1c_mask;
            if (tx_done && cur_ctrl[CW_IRQ])
                irq_status[IRQ_DONE] <= 1'b1;
            if (space_hit)
                irq_status[IRQ_SPACE] <= 1'b1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            irq <= 1'b0;
        else
            irq <= |(irq_status & irq_enable);
    end

    property p_irq_gate;
        @(posedge clock) disable iff (reset)
        ##1 irq == |($past(irq_status) & $past(irq_enable));
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq not gated by enable");

    property p_done_irq;
        @(posedge clock) disable iff (reset)
        tx_done && cur_ctrl[CW_IRQ] |=> irq_status[IRQ_DONE];
    endproperty
    a_done_irq: assert property (p_done_irq) else $error("done irq missing");

    property p_tag;
        @(posedge clock) disable iff (reset)
        tx_done |=> tx_frame_status[TAG_MSB:0] == $past(cur_ctrl[TAG_MSB:0])
                    && tx_frame_status[TXS_DONE];
    endproperty
    a_tag: assert property (p_tag) else $error("frame tag not reported");

    property p_release;
        @(posedge clock) disable iff (reset)
        tx_done && !enq |=> tx_free_memory == $past(tx_free_memory) + $past(cur_alloc);
    endproperty
    a_release: assert property (p_release) else $error("memory not released");

    property p_space;
        @(posedge clock) disable iff (reset)
        space_hit && !(reg_wr && wr_ofs == OFS_TX_QCMD) |=>
            irq_status[IRQ_SPACE] && !tx_queue_command[QC_SPACE];
    endproperty
    a_space: assert property (p_space) else $error("space irq missing");

    property p_manual_clear;
        @(posedge clock) disable iff (reset)
        tx_done && !(reg_wr && wr_ofs == OFS_TX_QCMD) |=> !tx_queue_command[QC_MANUAL];
    endproperty
    a_manual_clear: assert property (p_manual_clear) else $error("bit 0 kept");

    property p_start_gate;
        @(posedge clock) disable iff (reset)
        tx_state == TX_IDLE ##1 tx_state == TX_HDR |-> $past(tx_control[CTL_TX_EN]);
    endproperty
    a_start_gate: assert property (p_start_gate) else $error("sent while disabled");

    property p_w1c;
        @(posedge clock) disable iff (reset)
        $fell(irq_status[IRQ_DONE]) |-> $past(reg_wr && wr_ofs == OFS_IRQ_STAT);
    endproperty
    a_w1c: assert property (p_w1c) else $error("status cleared without write");

    // Bytes handed to the MAC in this frame; a stalled MAC makes a cycle bound useless
    logic [10:0] sent_cnt;

    always_ff @(posedge clock)
    begin
        if (reset || tx_state != TX_DATA)
            sent_cnt <= 11'h000;
        else if (mac_tx_valid && mac_tx_ready)
            sent_cnt <= sent_cnt + 11'h001;
    end

    property p_data_count;
        @(posedge clock) disable iff (reset)
        tx_done |-> sent_cnt == cur_len;
    endproperty
    a_data_count: assert property (p_data_count) else $error("frame length mismatch");

endmodule

// ---- verification/stq_spi_host.sv ----
// Host-side SPI master model driving the serial link
`timescale 1ns/1ps
module stq_spi_host (
    // Serial link
    output logic      spi_sclk,
    output logic      chip_select_n,
    output logic      spi_si,
    input  wire logic spi_so
);
    initial
    begin
        spi_sclk = 1'b0;
        chip_select_n = 1'b1;
        spi_si = 1'b1;
    end
    // One byte, 15 ns period; clock stands still outside frames
    task automatic xfer(input logic [7:0] b, output logic [7:0] r);
        for (int i = 7; i >= 0; i--)
        begin
            spi_si = b[i];
            #7.5 spi_sclk = 1'b1;
            r[i] = spi_so;
            #7.5 spi_sclk = 1'b0;
        end
        // Released line must not keep showing the last bit
        spi_si = ~b[0];
    endtask
    task automatic reg_op(input logic wr, input logic [7:0] ofs, input logic [15:0] wd,
                          output logic [15:0] rd);
        logic [7:0] r0;
        logic [7:0] r1;
        logic [3:0] en;
        en = ofs[1] ? 4'hc : 4'h3;
        chip_select_n = 1'b0;
        #7.5;
        xfer({1'b0, wr, en, ofs[7:6]}, r0);
        xfer({ofs[5:2], 4'h0}, r0);
        xfer(wd[7:0], r0);
        xfer(wd[15:8], r1);
        #7.5 chip_select_n = 1'b1;
        rd = {r1, r0};
        #40;
    endtask
    task automatic q_write(input logic [47:0] fr);
        logic [7:0] r;
        chip_select_n = 1'b0;
        #7.5;
        xfer(8'hc0, r);
        for (int k = 5; k >= 0; k--)
            xfer(fr[k*8 +: 8], r);
        #7.5 chip_select_n = 1'b1;
        #40;
    endtask
endmodule

// ---- verification/stq_top_bench.sv ----
// Self-checking bench for the SPI transmit queue manager
`timescale 1ns/1ps
module stq_top_bench;
    import stq_pkg::*;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic        mac_tx_ready = 1'b0;
    wire         spi_sclk, chip_select_n, spi_si, spi_so, spi_so_oe_n, irq;
    wire         mac_tx_valid, mac_tx_last, mac_tx_enable, mac_crc_enable;
    wire         mac_pad_enable, mac_flow_enable;
    wire [7:0]   mac_tx_data;
    int          fail_count = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    logic [15:0] rd;
    // Rows: write flag, offset, write data, expected read
    logic [40:0] rows [5] = '{{1'b0, OFS_TX_FREE, 16'h0, 16'h1800},
                              {1'b1, OFS_TX_CONTROL, 16'h000f, 16'h0},
                              {1'b0, OFS_TX_CONTROL, 16'h0, 16'h000f},
                              {1'b0, 8'h40, 16'h0, 16'h0},
                              {1'b0, OFS_IRQ_STAT, 16'h0, 16'h0}};
    stq_spi_host host (.spi_sclk(spi_sclk), .chip_select_n(chip_select_n),
                       .spi_si(spi_si), .spi_so(spi_so));
    stq_top dut (.clock(clock), .reset(reset), .spi_sclk(spi_sclk),
                 .chip_select_n(chip_select_n), .spi_si(spi_si), .spi_so(spi_so),
                 .spi_so_oe_n(spi_so_oe_n), .mac_tx_valid(mac_tx_valid),
                 .mac_tx_data(mac_tx_data), .mac_tx_last(mac_tx_last),
                 .mac_tx_ready(mac_tx_ready), .mac_tx_enable(mac_tx_enable),
                 .mac_crc_enable(mac_crc_enable), .mac_pad_enable(mac_pad_enable),
                 .mac_flow_enable(mac_flow_enable), .irq(irq));
    initial
    begin
        forever #2 clock = ~clock;
    end
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
        samples_checked++;
        if (seen !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
            fail_count++;
        end
    endtask
    task automatic test_done();
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic wait_for(input bit on_irq);
        for (int n = 0; n < 3000 && (on_irq ? irq : mac_tx_valid) !== 1'b1; n++)
        begin
            @(posedge clock);
            #0.5;
        end
    endtask
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            fail_count++;
            test_done();
        end
    end
    initial
    begin
        repeat (16) @(posedge clock);
        #0.5 reset = 1'b0;
        repeat (4) @(posedge clock);
        foreach (rows[i])
        begin
            host.reg_op(rows[i][40], rows[i][39:32], rows[i][31:16], rd);
            if (!rows[i][40])
                chk("register row", rows[i][15:0], rd);
        end
        chk("mac options", 16'h000f, {12'h0, mac_flow_enable, mac_pad_enable,
            mac_crc_enable, mac_tx_enable});
        host.reg_op(1'b1, OFS_RX_QCMD, 16'h0008, rd);
        host.reg_op(1'b1, OFS_TX_DPTR, 16'h4000, rd);
        host.reg_op(1'b1, OFS_IRQ_EN, 16'h4000, rd);
        host.reg_op(1'b1, OFS_TX_QCMD, 16'h0004, rd);
        // Control word irq plus tag 5, length 2, two data bytes, with the MAC stalled
        host.q_write(48'h0580_0200_a53c);
        wait_for(1'b0);
        repeat (5) @(posedge clock);
        #0.5 chk("stalled byte", 16'h01a5, {7'h0, mac_tx_valid, mac_tx_data});
        host.reg_op(1'b0, OFS_TX_FREE, 16'h0, rd);
        chk("free while queued", 16'h17f8, rd);
        @(posedge clock);
        #0.5 mac_tx_ready = 1'b1;
        @(posedge clock);
        #0.5 chk("last byte", 16'h033c, {6'h0, mac_tx_last, mac_tx_valid, mac_tx_data});
        @(posedge clock);
        #0.5 mac_tx_ready = 1'b0;
        wait_for(1'b1);
        chk("done irq", 16'h1, {15'h0, irq});
        host.reg_op(1'b0, OFS_TX_STATUS, 16'h0, rd);
        chk("frame status", 16'h8005, rd);
        host.reg_op(1'b0, OFS_TX_FREE, 16'h0, rd);
        chk("free after send", 16'h1800, rd);
        host.reg_op(1'b0, OFS_IRQ_STAT, 16'h0, rd);
        chk("irq status", 16'h4000, rd);
        host.reg_op(1'b1, OFS_IRQ_STAT, 16'hffff, rd);
        repeat (4) @(posedge clock);
        #0.5 chk("irq cleared", 16'h0, {15'h0, irq});
        // Manual enqueue: the frame waits for bit 0, then the bit clears itself
        host.reg_op(1'b1, OFS_TX_QCMD, 16'h0000, rd);
        host.q_write(48'h0600_0200_77e1);
        chk("held frame", 16'h0, {15'h0, mac_tx_valid});
        @(posedge clock);
        #0.5 mac_tx_ready = 1'b1;
        host.reg_op(1'b1, OFS_TX_QCMD, 16'h0001, rd);
        host.reg_op(1'b0, OFS_TX_QCMD, 16'h0, rd);
        chk("manual cleared", 16'h0, rd);
        host.reg_op(1'b0, OFS_TX_STATUS, 16'h0, rd);
        chk("second tag", 16'h8006, rd);
        // Space interrupt: 16 double words are free at once
        host.reg_op(1'b1, OFS_SPACE_REQ, 16'h0010, rd);
        host.reg_op(1'b1, OFS_IRQ_EN, 16'h0040, rd);
        host.reg_op(1'b1, OFS_TX_QCMD, 16'h0002, rd);
        host.reg_op(1'b0, OFS_IRQ_STAT, 16'h0, rd);
        chk("space irq", 16'h0040, rd);
        chk("space irq pin", 16'h1, {15'h0, irq});
        // Mid-run reset returns registers and pins to their idle state
        @(posedge clock);
        #0.5 reset = 1'b1;
        repeat (4) @(posedge clock);
        #0.5 reset = 1'b0;
        repeat (4) @(posedge clock);
        host.reg_op(1'b0, OFS_TX_CONTROL, 16'h0, rd);
        chk("control after reset", 16'h0, rd);
        chk("pins after reset", 16'h1, {13'h0, irq, mac_tx_enable, spi_so_oe_n});
        test_done();
    end
endmodule
